//--- verilog/ccr_regs.sv
// Purpose: configuration register set of a removable flash card
// Assumes: attribute strobes are synchronous to mclk_i, one-cycle pulses
// Notes:   the ready pin and ide strap come from pins and are synchronised
module ccr_regs
	import ccr_pkg::*;
#(
	parameter int IDLE_CY = CCR_IDLE_CY
) (
	// clock, reset, enable
	input  wire logic     mclk_i,
	input  wire logic     arst_n_i,
	input  wire logic     ce_i,
	// attribute register access
	input  wire ccr_req_s req_i,
	output logic [7:0]    rdata_o,
	output logic          rvalid_o,
	// task-file decode of the active address map
	input  wire logic     tf_reg_n_i,
	input  wire logic [10:0] tf_addr_i,
	output ccr_tf_s       tf_dec_o,
	// card state
	input  wire logic     ide_mode_i,
	input  wire logic     io_config_i,
	input  wire logic     ready_pin_i,
	input  wire logic     irq_req_i,
	input  wire logic     irq_disable_bit_i,
	input  wire logic     cmd_strobe_i,
	output logic          card_reset_o,
	output logic          irq_level_select_o,
	output logic          narrow_bus_flag_o,
	output logic          sleep_o,
	output logic          status_change_pin_n_o
);

	// ==========================================================
	// synchronisers for pin inputs
	logic [1:0] rdy_sync_r;
	logic [1:0] ide_sync_r;

	// first stage feeds only the second
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdy_sync_r <= 2'b00;
			ide_sync_r <= 2'b00;
		end else if (ce_i) begin
			rdy_sync_r <= {rdy_sync_r[0], ready_pin_i};
			ide_sync_r <= {ide_sync_r[0], ide_mode_i};
		end
	end

	logic rdy_s;
	logic ide_s;
	assign rdy_s = rdy_sync_r[1];
	assign ide_s = ide_sync_r[1];

	// ==========================================================
	// access decode
	logic acc_ok;
	logic wr_opt;
	logic wr_st;
	logic wr_pin;
	logic wr_copy;

	// no access at all in disk-compatible mode
	assign acc_ok  = !ide_s;                                   // [R20]
	assign wr_opt  = acc_ok && req_i.wr && req_i.addr == CCR_OPTION_OFS;
	assign wr_st   = acc_ok && req_i.wr && req_i.addr == CCR_STATE_OFS;
	assign wr_pin  = acc_ok && req_i.wr && req_i.addr == CCR_PIN_OFS;
	assign wr_copy = acc_ok && req_i.wr && req_i.addr == CCR_COPY_OFS;

	// ==========================================================
	// option register
	logic       srst_r;
	logic       lvl_r;
	logic [5:0] map_r;

	// soft reset sticks; it clears level and map but not itself
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			srst_r <= CCR_OPTION_RST[CCR_OPT_SRST_BIT];          // [R2]
			lvl_r  <= CCR_OPTION_RST[CCR_OPT_LVL_BIT];
			map_r  <= CCR_OPTION_RST[5:0];                      // [R5]
		end else if (ce_i) begin
			if (wr_opt) begin
				srst_r <= req_i.wdata[CCR_OPT_SRST_BIT];         // [R1] [R2]
				lvl_r  <= req_i.wdata[CCR_OPT_LVL_BIT];          // [R4]
				map_r  <= req_i.wdata[5:0];
			end
			// a releasing write keeps the level and map it carries
			if (wr_opt ? req_i.wdata[CCR_OPT_SRST_BIT] : srst_r) begin
				lvl_r <= CCR_OPTION_RST[CCR_OPT_LVL_BIT];
				map_r <= CCR_MAP_MEM;                           // [R5]
			end
		end
	end

	assign card_reset_o       = srst_r;                          // [R1]
	assign irq_level_select_o = lvl_r;                           // [R4]

	// ==========================================================
	// configuration and status register
	logic sig_r;
	logic io8_r;
	logic pwd_r;

	// host bits are cleared while soft reset holds the card
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sig_r <= CCR_STATE_RST[CCR_ST_SIG_BIT];
			io8_r <= CCR_STATE_RST[CCR_ST_IO8_BIT];
			pwd_r <= CCR_STATE_RST[CCR_ST_PWD_BIT];
		end else if (ce_i) begin
			if (srst_r) begin
				sig_r <= 1'b0;                                  // [R2]
				io8_r <= 1'b0;
				pwd_r <= 1'b0;
			end else if (wr_st) begin
				sig_r <= req_i.wdata[CCR_ST_SIG_BIT];            // [R10]
				io8_r <= req_i.wdata[CCR_ST_IO8_BIT];            // [R11]
				pwd_r <= req_i.wdata[CCR_ST_PWD_BIT];            // [R12]
			end
		end
	end

	assign narrow_bus_flag_o = io8_r;

	// ==========================================================
	// power state machine
	ccr_pwr_e ps_r;
	logic [$clog2(CCR_PWR_SETTLE_CY+1)-1:0] settle_r;
	logic [$clog2(IDLE_CY+1)-1:0]          idle_r;
	logic                                  pwd_seen_r;
	logic                                  pwd_chg;
	logic                                  auto_sleep_r;

	assign pwd_chg = pwd_seen_r != pwd_r;

	// a changed request restarts the settle count, except in wake, which runs to completion
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ps_r       <= CCR_PS_ACTIVE;
			settle_r   <= '0;
			pwd_seen_r <= 1'b0;
		end else if (ce_i) begin
			pwd_seen_r <= pwd_r;
			unique case (ps_r)
				CCR_PS_ACTIVE: if (pwd_r || auto_sleep_r) begin
					ps_r     <= CCR_PS_ENTER;                     // [R12]
					settle_r <= '0;
				end
				CCR_PS_ENTER: begin
					if (!pwd_r && !auto_sleep_r) begin
						ps_r     <= CCR_PS_WAKE;
						settle_r <= '0;
					end else if (settle_r ==
						($bits(settle_r))'(CCR_PWR_SETTLE_CY - 1)) begin
						ps_r <= CCR_PS_SLEEP;
					end else begin
						settle_r <= settle_r + 1'b1;
					end
				end
				CCR_PS_SLEEP: if (!pwd_r && !auto_sleep_r) begin
					ps_r     <= CCR_PS_WAKE;                      // [R12]
					settle_r <= '0;
				end
				CCR_PS_WAKE: begin
					if (settle_r ==
						($bits(settle_r))'(CCR_PWR_SETTLE_CY - 1)) begin
						ps_r <= CCR_PS_ACTIVE;
					end else begin
						settle_r <= settle_r + 1'b1;
					end
				end
			endcase
		end
	end

	// idle counter: sleep when quiet, a command wakes the card
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			idle_r       <= '0;
			auto_sleep_r <= 1'b0;
		end else if (ce_i) begin
			if (cmd_strobe_i || srst_r) begin
				idle_r       <= '0;
				auto_sleep_r <= 1'b0;                           // [R14]
			end else if (idle_r == ($bits(idle_r))'(IDLE_CY)) begin
				auto_sleep_r <= 1'b1;                           // [R14]
			end else begin
				idle_r <= idle_r + 1'b1;
			end
		end
	end

	assign sleep_o = ps_r == CCR_PS_SLEEP;

	// busy from the change until the requested state is reached
	logic pwr_busy;
	assign pwr_busy = pwd_chg ||
		(pwd_r ? ps_r != CCR_PS_SLEEP : ps_r != CCR_PS_ACTIVE) &&
		!(auto_sleep_r && !pwd_r);                                // [R13]

	logic rrdy;
	assign rrdy = rdy_s && !pwr_busy;                             // [R13] [R18]

	// ==========================================================
	// pin replacement register
	logic       crdy_r;
	logic       rrdy_d_r;
	logic       rmask_r;
	logic [2:0] prime_r;

	// a ready change wins over a host write in the same cycle;
	// edges are ignored until the synchroniser and the delay stage
	// hold real pin samples, so a pin idling ready after reset
	// does not look like a change
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			crdy_r   <= CCR_PIN_FIXED[CCR_PIN_CRDY_BIT];
			rrdy_d_r <= 1'b0;
			rmask_r  <= 1'b0;
			prime_r  <= 3'h0;
		end else if (ce_i) begin
			rrdy_d_r <= rrdy;
			prime_r  <= {prime_r[1:0], 1'b1};
			if (wr_pin) begin
				crdy_r  <= req_i.wdata[CCR_PIN_CRDY_BIT];        // [R17]
				rmask_r <= req_i.wdata[CCR_PIN_RRDY_BIT];        // [R18]
			end
			if (prime_r[2] && rrdy != rrdy_d_r && !rmask_r) begin
				crdy_r <= 1'b1;                                 // [R17]
			end
			if (srst_r) begin
				crdy_r  <= 1'b0;
				rmask_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// socket and copy register
	logic copy_r;

	// only the copy number bit is stored
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			copy_r <= CCR_COPY_RST[CCR_COPY_BIT];
		end else if (ce_i && wr_copy) begin
			copy_r <= req_i.wdata[CCR_COPY_BIT];                 // [R19]
		end
	end

	// ==========================================================
	// status change pin and interrupt pending
	logic chg;
	logic irq_pending;
	assign chg  = crdy_r;                                        // [R9]
	assign irq_pending = irq_req_i && !irq_disable_bit_i;               // [R15] [R16]

	// registered so the pin never glitches
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_change_pin_n_o <= 1'b1;
		end else if (ce_i) begin
			status_change_pin_n_o <= !(chg && sig_r && io_config_i); // [R9] [R10]
		end
	end

	// ==========================================================
	// read data
	function automatic logic [7:0] rd_mux(input logic [10:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			CCR_OPTION_OFS: v = {srst_r, lvl_r, map_r};
			CCR_STATE_OFS: begin
				v[CCR_ST_CHG_BIT] = chg;
				v[CCR_ST_SIG_BIT] = sig_r;
				v[CCR_ST_IO8_BIT] = io8_r;
				v[CCR_ST_PWD_BIT] = pwd_r;
				v[CCR_ST_INT_BIT] = irq_pending;                       // [R15]
			end
			CCR_PIN_OFS: begin
				v = CCR_PIN_FIXED;                              // [R21]
				v[CCR_PIN_CRDY_BIT] = crdy_r;
				v[CCR_PIN_RRDY_BIT] = rrdy;                     // [R18]
			end
			CCR_COPY_OFS: v[CCR_COPY_BIT] = copy_r;              // [R21]
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// one-cycle answer; nothing returned in disk-compatible mode
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= req_i.rd && acc_ok;                      // [R20]
			rdata_o  <= (req_i.rd && acc_ok) ? rd_mux(req_i.addr) : 8'h00;
		end
	end

	// ==========================================================
	// task-file decode per map select
	function automatic ccr_tf_s tf_map(input logic [5:0] m,
		input logic rn, input logic [10:0] a);
		ccr_tf_s t;
		t = '0;
		unique case (m)
			CCR_MAP_MEM: if (rn && (a[10] || a[9:4] == 6'h00)) begin
				t.hit = 1'b1;                                   // [R6]
				t.idx = a[10] ? {3'b100, a[0]} : a[3:0];
			end
			CCR_MAP_CONT: if (!rn) begin
				t.hit = 1'b1;                                   // [R6]
				t.idx = a[3:0];
			end
			CCR_MAP_PRI: if (!rn) begin
				if (a[9:3] == 7'h3e) begin
					t.hit = 1'b1;                               // [R7]
					t.idx = {1'b0, a[2:0]};
				end else if (a[9:1] == 9'h1fb) begin
					t.hit = 1'b1;                               // [R7]
					t.idx = {3'b111, a[0]};
				end
			end
			CCR_MAP_SEC: if (!rn) begin
				if (a[9:3] == 7'h2e) begin
					t.hit = 1'b1;                               // [R8]
					t.idx = {1'b0, a[2:0]};
				end else if (a[9:1] == 9'h1bb) begin
					t.hit = 1'b1;                               // [R8]
					t.idx = {3'b111, a[0]};
				end
			end
			default: t = '0;
		endcase
		return t;
	endfunction

	// no task-file hits while soft reset holds the card
	assign tf_dec_o = srst_r ? '0 : tf_map(map_r, tf_reg_n_i, tf_addr_i);

endmodule

//--- verilog/ccr_pkg.sv
// Purpose: constants and carriers for the card configuration register set
// Assumes: byte-wide attribute accesses at even addresses, 40 MHz mclk_i
// Notes:   register offsets are attribute-space byte addresses
//
// Contract
// [R1] writing one to soft reset holds the card in reset; bit stays set
// [R2] writing zero releases reset; hard reset clears bit and config state
// [R3] host repeats power-on access sequence after any card reset
// [R4] level select zero gives pulse interrupts, one gives level interrupts
// [R5] map select field returns to zero on power on, hard and soft reset
// [R6] map 0 decodes memory 0h-fh and 400h-7ffh; map 1 contiguous i/o
// [R7] map 2 decodes primary i/o 1f0h-1f7h and 3f6h-3f7h
// [R8] map 3 decodes secondary i/o 170h-177h and 376h-377h
// [R9] changed flag mirrors ready-change; status pin low when enabled in i/o
// [R10] change enable gates status pin; zero keeps it high
// [R11] host sets narrow bus flag when limited to eight-bit low lanes
// [R12] power down one enters sleep, zero returns to idle active
// [R13] power down change shows busy until requested state is entered
// [R14] card powers down when idle and wakes on a command
// [R15] interrupt pending mirrors internal request until serviced
// [R16] interrupt pending reads zero while interrupts are disabled
// [R17] ready-change sets when ready state changes; host may write it
// [R18] ready state reads ready pin; write masks ready-change flag
// [R19] host writes copy number before option register on shared bus
// [R20] registers are inaccessible in disk-interface-compatible mode
// [R21] fixed bits ignore writes and read their fixed values
package ccr_pkg;

	// ==========================================================
	// register offsets
	localparam logic [10:0] CCR_OPTION_OFS = 11'h200;
	localparam logic [10:0] CCR_STATE_OFS  = 11'h202;
	localparam logic [10:0] CCR_PIN_OFS    = 11'h204;
	localparam logic [10:0] CCR_COPY_OFS   = 11'h206;

	// ==========================================================
	// field positions
	localparam int CCR_OPT_SRST_BIT = 7;
	localparam int CCR_OPT_LVL_BIT  = 6;
	localparam int CCR_ST_CHG_BIT   = 7;
	localparam int CCR_ST_SIG_BIT   = 6;
	localparam int CCR_ST_IO8_BIT   = 5;
	localparam int CCR_ST_PWD_BIT   = 2;
	localparam int CCR_ST_INT_BIT   = 1;
	localparam int CCR_PIN_CRDY_BIT = 5;
	localparam int CCR_PIN_RRDY_BIT = 1;
	localparam int CCR_COPY_BIT     = 4;

	// ==========================================================
	// reset and fixed values
	localparam logic [7:0] CCR_OPTION_RST = 8'h00;
	localparam logic [7:0] CCR_STATE_RST  = 8'h00;
	localparam logic [7:0] CCR_PIN_FIXED  = 8'h0c;
	localparam logic [7:0] CCR_COPY_RST   = 8'h00;
	localparam logic [5:0] CCR_MAP_MEM    = 6'h00;
	localparam logic [5:0] CCR_MAP_CONT   = 6'h01;
	localparam logic [5:0] CCR_MAP_PRI    = 6'h02;
	localparam logic [5:0] CCR_MAP_SEC    = 6'h03;

	// ==========================================================
	// timing: power state transition time and idle time before sleep
	localparam int CCR_CLK_MHZ       = 40;
	localparam int CCR_PWR_SETTLE_NS = 1000;
	localparam int CCR_PWR_SETTLE_CY =
		(CCR_PWR_SETTLE_NS * CCR_CLK_MHZ + 999) / 1000;
	localparam int CCR_IDLE_US       = 100;
	localparam int CCR_IDLE_CY       = CCR_IDLE_US * CCR_CLK_MHZ;

	// ==========================================================
	// power state machine, gray coded
	typedef enum logic [1:0] {
		CCR_PS_ACTIVE = 2'b00,
		CCR_PS_ENTER  = 2'b01,
		CCR_PS_SLEEP  = 2'b11,
		CCR_PS_WAKE   = 2'b10
	} ccr_pwr_e;

	// attribute access request carried as one bundle
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [10:0] addr;
		logic [7:0]  wdata;
	} ccr_req_s;

	// task-file decode result
	typedef struct packed {
		logic       hit;
		logic [3:0] idx;
	} ccr_tf_s;

endpackage

//--- tb/ccr_regs_sva.sv
// Purpose: port checks on the card configuration register set
// Assumes: ide strap passes a two-stage synchroniser in the design
// Notes:   accesses count only once the strap has sat low three edges
module ccr_regs_chk
	import ccr_pkg::*;
#(
	parameter int IDLE_CY = CCR_IDLE_CY
) (
	// clock and reset
	input wire logic     mclk_i,
	input wire logic     arst_n_i,
	// watched inputs
	input wire logic     ce_i,
	input wire ccr_req_s req_i,
	input wire logic     ide_mode_i,
	input wire logic     io_config_i,
	// watched outputs
	input wire logic     rvalid_o,
	input wire ccr_tf_s  tf_dec_o,
	input wire logic     card_reset_o,
	input wire logic     irq_level_select_o,
	input wire logic     narrow_bus_flag_o,
	input wire logic     sleep_o,
	input wire logic     status_change_pin_n_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// strap history; reset to ones so nothing counts as accepted early
	logic [2:0] ide_hist_r;
	logic [2:0] up_r;
	logic       ok;
	logic       wr_opt;
	logic       wr_st;
	// up_r marks edges since reset; the design's strap stage
	// holds no real sample before the second one
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ide_hist_r <= 3'h7;
			up_r       <= 3'h0;
		end else begin
			ide_hist_r <= {ide_hist_r[1:0], ide_mode_i};
			up_r       <= {up_r[1:0], 1'b1};
		end
	end
	// worst case: a wake still settling, then a full entry
	localparam int SLEEP_MAX = 2 * CCR_PWR_SETTLE_CY + 4;
	assign ok     = ce_i && !ide_mode_i && ide_hist_r == 3'h0;
	assign wr_opt = ok && req_i.wr && req_i.addr == CCR_OPTION_OFS;
	assign wr_st  = ok && req_i.wr && req_i.addr == CCR_STATE_OFS
		&& !card_reset_o;

	// ==========================================================
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_srst_set: assert property (wr_opt && req_i.wdata[7] |=> card_reset_o)
		else $error("soft reset not taken");
	a_srst_clr: assert property (wr_opt && !req_i.wdata[7] |=> !card_reset_o)
		else $error("soft reset not released");
	a_srst_nodec: assert property (card_reset_o |-> !tf_dec_o.hit)
		else $error("decode active in reset");
	a_level_sel: assert property (wr_opt && !req_i.wdata[7]
		|=> irq_level_select_o == $past(req_i.wdata[6]))
		else $error("level select wrong");
	a_narrow_bus: assert property (wr_st
		|=> narrow_bus_flag_o == $past(req_i.wdata[5]))
		else $error("narrow bus flag wrong");
	a_sleep_enter: assert property (wr_st && req_i.wdata[2] && !sleep_o
		|-> ##[1:SLEEP_MAX] sleep_o)
		else $error("sleep not entered");
	a_pin_gate: assert property (!status_change_pin_n_o |-> $past(io_config_i))
		else $error("status pin low outside io");
	a_read_ans: assert property (ok && req_i.rd |=> rvalid_o)
		else $error("read not answered");
	a_ide_refuse: assert property (ide_mode_i && ide_hist_r == 3'h7
		&& up_r == 3'h7 |=> !rvalid_o)
		else $error("read answered in disk mode");
endmodule

bind ccr_regs ccr_regs_chk #(.IDLE_CY(IDLE_CY)) u_ccr_regs_chk (
	.mclk_i(mclk_i),
	.arst_n_i(arst_n_i),
	.ce_i(ce_i),
	.req_i(req_i),
	.ide_mode_i(ide_mode_i),
	.io_config_i(io_config_i),
	.rvalid_o(rvalid_o),
	.tf_dec_o(tf_dec_o),
	.card_reset_o(card_reset_o),
	.irq_level_select_o(irq_level_select_o),
	.narrow_bus_flag_o(narrow_bus_flag_o),
	.sleep_o(sleep_o),
	.status_change_pin_n_o(status_change_pin_n_o)
);

//--- tb/ccr_host.sv
// Purpose: host side of the attribute register access
// Assumes: one access per call, launched at a falling edge
// Notes:   idle lines carry inverted junk, as nothing qualifies them
module ccr_host
	import ccr_pkg::*;
(
	// clock
	input  wire logic       mclk_i,
	// request out, answer in
	output ccr_req_s        req_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req_o = '0;

	// ==========================================================
	// request held over one rising edge, answer taken at the next fall
	task automatic acc(input logic w, input logic [10:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic v);
		@(negedge mclk_i);
		req_o = '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge mclk_i);
		q = rdata_i;
		v = rvalid_i;
		req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

//--- tb/ccr_regs_test.sv
// Purpose: self-checking bench for the configuration register set
// Assumes: idle time shortened to 20 cycles, settle time 40 cycles
// Notes:   a background strobe keeps the card awake unless paused
module ccr_regs_test
	import ccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int IDLE = 20;
	logic        mclk_i, arst_n_i, ide, io_cfg, rdy, irq, irq_dis;
	logic        cmd, rn, keep, rvalid, v, card_rst, lvl, nb, slp;
	logic        status_change_pin_n, ce;
	logic [4:0]  xt;
	logic [10:0] tfa;
	logic [7:0]  rdata, q, d;
	ccr_req_s    req;
	ccr_tf_s     tf;
	int          fails, n_compared, cyc, seed, i, m;
	logic [10:0] cor [12] = '{11'h005, 11'h400, 11'h7ff, 11'h010,
		11'h1f0, 11'h1f7, 11'h1f8, 11'h3f6, 11'h3f7, 11'h170,
		11'h177, 11'h376};

	ccr_regs #(.IDLE_CY(IDLE)) u_ccr_regs (.mclk_i(mclk_i),
		.arst_n_i(arst_n_i), .ce_i(ce), .req_i(req), .rdata_o(rdata),
		.rvalid_o(rvalid), .tf_reg_n_i(rn), .tf_addr_i(tfa),
		.tf_dec_o(tf), .ide_mode_i(ide), .io_config_i(io_cfg),
		.ready_pin_i(rdy), .irq_req_i(irq), .irq_disable_bit_i(irq_dis),
		.cmd_strobe_i(cmd), .card_reset_o(card_rst),
		.irq_level_select_o(lvl), .narrow_bus_flag_o(nb),
		.sleep_o(slp), .status_change_pin_n_o(status_change_pin_n));
	ccr_host u_ccr_host (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata),
		.rvalid_i(rvalid));

	// ==========================================================
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// keep-alive strobe; paused only where sleep is the point
	always @(negedge mclk_i) begin
		cmd <= keep && cyc[2:0] == 3'h0;
	end
	// hang guard, far above the few hundred cycles used
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end

	// ==========================================================
	task automatic chk(input logic [8:0] got, input logic [8:0] exp,
		input string w);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	task automatic rd(input logic [10:0] a, input logic [7:0] e,
		input string w);
		u_ccr_host.acc(1'b0, a, 8'h00, q, v);
		chk({v, q}, {1'b1, e}, w);
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] dd);
		u_ccr_host.acc(1'b1, a, dd, q, v);
	endtask
	task automatic await(input logic e, input string w);
		int n;
		n = 0;
		while (slp !== e && n < 120) begin
			@(negedge mclk_i);
			n++;
		end
		chk({8'h0, slp}, {8'h0, e}, w);
	endtask
	// {hit, index}; a10 is a don't-care in both fixed i/o maps
	function automatic logic [4:0] exp_tf(int mp, logic r,
		logic [10:0] a);
		logic p;
		logic s;
		p = a[9:3] == (mp == 2 ? 7'h3e : 7'h2e);
		s = a[9:1] == (mp == 2 ? 9'h1fb : 9'h1bb);
		if (mp == 0 && r && a[10])
			return {2'b11, 2'b00, a[0]};
		if (mp == 0 && r && a[9:4] == 6'h00 || mp == 1 && !r)
			return {1'b1, a[3:0]};
		if (mp > 1 && !r && p)
			return {2'b10, a[2:0]};
		if (mp > 1 && !r && s)
			return {4'hf, a[0]};
		return 5'h00;
	endfunction
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	initial begin
		{ide, io_cfg, rdy, irq, irq_dis, rn, tfa, arst_n_i} = '0;
		{fails, n_compared, cyc} = '0;
		seed = 99718;
		keep = 1'b1;
		ce = 1'b1;
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i) arst_n_i = 1'b1;
		rd(CCR_OPTION_OFS, 8'h00, "opt rst");
		rd(CCR_STATE_OFS, 8'h00, "st rst");
		rd(CCR_PIN_OFS, 8'h0c, "pin rst");
		rd(11'h208, 8'h00, "unmapped");
		// copy number first, then option, as after power on
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			m = i % 4;
			wr(CCR_COPY_OFS, d);
			rd(CCR_COPY_OFS, d & 8'h10, "copy");
			wr(CCR_OPTION_OFS, {1'b0, d[6], 6'(m)});
			rd(CCR_OPTION_OFS, {1'b0, d[6], 6'(m)}, "opt");
			chk({8'h0, lvl}, {8'h0, d[6]}, "lvl");
			for (int k = 0; k < 16; k++) begin
				@(negedge mclk_i);
				rn = k[0] ^ i[2];
				tfa = k < 12 ? cor[k] : 11'($random(seed));
				xt = exp_tf(m, rn, tfa);
				#1 chk({4'h0, tf}, {4'h0, xt}, "tf");
			end
		end
		wr(CCR_STATE_OFS, 8'hfb);
		rd(CCR_STATE_OFS, 8'h60, "st bits");
		chk({8'h0, nb}, 9'h1, "narrow");
		irq = 1'b1;
		rd(CCR_STATE_OFS, 8'h62, "irq_pending");
		irq_dis = 1'b1;
		rd(CCR_STATE_OFS, 8'h60, "irq_pending off");
		{irq, irq_dis} = 2'b00;
		wr(CCR_OPTION_OFS, 8'hc3);
		chk({8'h0, card_rst}, 9'h1, "srst");
		rd(CCR_OPTION_OFS, 8'h80, "srst held");
		rd(CCR_STATE_OFS, 8'h00, "st cleared");
		wr(CCR_OPTION_OFS, 8'h00);
		chk({8'h0, card_rst}, 9'h0, "srst off");
		wr(CCR_STATE_OFS, 8'h40);
		io_cfg = 1'b1;
		rdy = 1'b1;
		repeat (4) @(negedge mclk_i);
		chk({8'h0, status_change_pin_n}, 9'h0, "pin low");
		rd(CCR_PIN_OFS, 8'h2e, "crdy");
		rd(CCR_STATE_OFS, 8'hc0, "changed_flag");
		wr(CCR_STATE_OFS, 8'h00);
		@(negedge mclk_i);
		chk({8'h0, status_change_pin_n}, 9'h1, "pin gated");
		wr(CCR_PIN_OFS, 8'h02);
		rdy = 1'b0;
		repeat (4) @(negedge mclk_i);
		rd(CCR_PIN_OFS, 8'h0c, "masked");
		rdy = 1'b1;
		repeat (4) @(negedge mclk_i);
		keep = 1'b0;
		wr(CCR_STATE_OFS, 8'h04);
		rd(CCR_PIN_OFS, 8'h0c, "busy");
		await(1'b1, "asleep");
		rd(CCR_PIN_OFS, 8'h0e, "ready");
		keep = 1'b1;
		wr(CCR_STATE_OFS, 8'h00);
		await(1'b0, "awake");
		keep = 1'b0;
		await(1'b1, "idle sleep");
		keep = 1'b1;
		await(1'b0, "cmd wake");
		wr(CCR_COPY_OFS, 8'h00);
		ide = 1'b1;
		repeat (4) @(negedge mclk_i);
		u_ccr_host.acc(1'b0, CCR_OPTION_OFS, 8'h00, q, v);
		chk({8'h0, v}, 9'h0, "ide read");
		wr(CCR_COPY_OFS, 8'h10);
		ide = 1'b0;
		repeat (4) @(negedge mclk_i);
		rd(CCR_COPY_OFS, 8'h00, "ide write");
		// a write while the enable is low must leave no trace
		ce = 1'b0;
		wr(CCR_COPY_OFS, d | 8'h10);
		ce = 1'b1;
		rd(CCR_COPY_OFS, 8'h00, "ce frozen");
		conclude();
	end
endmodule
